//--- design/tsm_pkg.sv
/*
  Constants, register map and state encodings for the touch sensor
  mode and low-power controller.
  Assumes a 100 MHz core clock and a 7-bit I2C slave address.
*/
package tsm_pkg;
  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MASTER_TICK = 8'h0E;
  localparam logic [7:0] ADDR_LOW_POWER = 8'h11;
  localparam logic [7:0] ADDR_MODE_CONFIG = 8'h13;
  localparam logic [7:0] RST_MASTER_TICK = 8'h05;
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  localparam logic [7:0] RST_MODE_CONFIG = 8'h14;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CFG_RUN_BIT = 0;
  localparam int CFG_INTERRUPT_ENABLE_BIT_BIT = 1;
  localparam int CFG_DUTY_N_BIT = 2;
  localparam int CFG_RSVD_BIT = 3;
  localparam int CFG_SOFTRST_N_BIT = 4;
  localparam int CFG_RATE_LSB = 5;
  localparam int LP_IDLE_LSB = 5;
  localparam int LP_SLEEP_LSB = 0;
  // ---------------------------------------------------------------
  // tick and scan arithmetic
  // ---------------------------------------------------------------
  localparam logic [7:0] TICK_OFFSET_MS = 8'h05;
  localparam logic [7:0] TICK_FIELD_MAX = 8'h1A;
  localparam logic [7:0] TICK_FORCE_VAL = 8'h1A;
  localparam logic [7:0] FIXED_TICK_MS = 8'h08;
  localparam logic [2:0] DEBOUNCE_MULT = 3'h4;
  localparam logic [2:0] IDLE_MULT = 3'h6;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_IN_NS = 1000000;
  localparam int MS_CYC = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 17;
  localparam logic [6:0] DEF_SLAVE_ADDR = 7'h5D;  // arbitrary value
  // ---------------------------------------------------------------
  // I2C slave states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACKA = 4'b0010,
    ST_REG = 4'b0011,
    ST_ACKR = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACKW = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000
  } tsm_i2c_st_t;
endpackage : tsm_pkg

//--- design/tsm_mode_ctrl.sv
/*
  Operating-mode, tick and low-power scan controller with its I2C
  register slave (master tick, low power and mode configuration).
  Assumes SCL, SDA and the attention pin arrive asynchronously; the
  sample period, touch and interrupt-issued inputs come from logic
  on the same clock. SDA is open drain, resolved outside.
*/
//
// Behaviour
// - full run scans, I2C up, master tick
// - master tick only in full run; else 8ms
// - tick out of range forced to 0x1A
// - primary tick equals field plus five ms
// - duty-cycled run sleeps between scans, I2C unanswered
// - attention or a soft reset exits duty-cycled run; only attention exits off
// - idle stop answers, accepts all writes
// - off stop: no scan, no I2C
// - interrupt spacing is rate plus one ticks
// - config bit4 low applies global reset
// - config bit2 low enables duty cycling
// - config bit1 gates interrupt function
// - config bit0 high enables scanning
// - attention falling edge sets duty-cycle bit
// - low-power rate switching only in duty-cycled run
// - normal period k*sample*4*8ms
// - idle timeout k*sample*idle*6*8ms
// - normal first, sleep after idle, touch returns
// - idle field zero disables low power
// - sleep field zero disables low power
// - run modes accept only config writes
// - reset values 0x14, 0x05, 0x00
`timescale 1ns/100ps
`default_nettype none
module tsm_mode_ctrl
  import tsm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
)
(
  input wire logic clock,  // core clock
  input wire logic rst,  // synchronous reset, active high
  input wire logic sclIn,  // I2C clock pin
  input wire logic sdaIn,  // I2C data pin level
  output logic sdaOut,  // I2C data drive value
  output logic sdaOe,  // I2C data drive enable
  input wire logic attentionInput,  // attention pin
  input wire logic [7:0] samplePeriod,  // sample period field
  input wire logic touchDetected,  // touch seen this cycle
  input wire logic irqIssued,  // interrupt just raised
  output logic irqAllowed,  // interrupt may be raised now
  output logic masterTick,  // one-cycle tick pulse
  output logic scanStrobe,  // one-cycle scan start
  output logic scanEnable,  // a run mode is active
  output logic sleepScan,  // scanning at sleep period
  output logic sensorReset,  // one-cycle global reset
  output logic [1:0] modeOut  // {run, duty_n}
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl1, scl2, sclPrev;
    logic sda1, sda2, sdaPrev;
    logic att1, att2, attPrev;
    tsm_i2c_st_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic [7:0] ptr;
    logic sdaDrive;
    logic [7:0] tickField;
    logic [7:0] lowPower;
    logic [7:0] modeCfg;
    logic [MS_CNT_W-1:0] msCnt;
    logic [MS_CNT_W-1:0] awakeCnt;
    logic [7:0] tickMsCnt;
    logic tick;
    logic [3:0] irqGap;
    logic [19:0] scanCnt;
    logic [19:0] idleCnt;
    logic sleep;
    logic scan;
    logic swReset;
  } tsm_state_t;

  tsm_state_t s_reg, s_next;

  // scan-period arithmetic in units of 8ms ticks
  function automatic logic [19:0] tsm_ticks(input logic [7:0] tick, input logic [7:0] sample_period_field,
                                            input logic [4:0] factor, input logic [2:0] mult);
    logic [31:0] prod;
    prod = (({24'h000000, tick} + {24'h000000, TICK_OFFSET_MS}) / 32'h00000008 + 32'h00000001)
           * {24'h000000, sample_period_field} * {27'h0000000, factor} * {29'h00000000, mult};
    return prod[19:0];
  endfunction : tsm_ticks

  function automatic logic [7:0] tsm_read(input tsm_state_t s);
    case (s.ptr)
      ADDR_MASTER_TICK: return s.tickField;
      ADDR_LOW_POWER: return s.lowPower;
      ADDR_MODE_CONFIG: return s.modeCfg;
      default: return RD_UNMAPPED;
    endcase
  endfunction : tsm_read

  // ---------------------------------------------------------------
  // decoded modes and derived values
  // ---------------------------------------------------------------
  logic runBit, dutyN, fullRun, dcRun, idleStop, offStop;
  logic sclRise, sclFall, startCond, stopCond, attFall;
  logic awake, lpEnabled;
  logic [7:0] tickMs;
  logic [2:0] idleFactor;
  logic [4:0] sleepFactor;
  logic [19:0] normalPer, sleepPer, idleTimeout, curPer;
  logic [7:0] wrData;

  assign runBit = s_reg.modeCfg[CFG_RUN_BIT];
  assign dutyN = s_reg.modeCfg[CFG_DUTY_N_BIT];
  assign fullRun = runBit & dutyN;
  assign dcRun = runBit & ~dutyN;
  assign idleStop = ~runBit & dutyN;
  assign offStop = ~runBit & ~dutyN;
  assign sclRise = s_reg.scl2 & ~s_reg.sclPrev;
  assign sclFall = ~s_reg.scl2 & s_reg.sclPrev;
  assign startCond = s_reg.scl2 & s_reg.sclPrev & s_reg.sdaPrev & ~s_reg.sda2;
  assign stopCond = s_reg.scl2 & s_reg.sclPrev & ~s_reg.sdaPrev & s_reg.sda2;
  assign attFall = s_reg.attPrev & ~s_reg.att2;
  // the tick field only counts in full run; elsewhere the fixed 8ms tick
  assign tickMs = fullRun ? s_reg.tickField + TICK_OFFSET_MS : FIXED_TICK_MS;
  assign idleFactor = s_reg.lowPower[LP_IDLE_LSB +: 3];
  assign sleepFactor = s_reg.lowPower[LP_SLEEP_LSB +: 5];
  assign lpEnabled = dcRun & (idleFactor != 3'h0) & (sleepFactor != 5'h00);
  assign normalPer = tsm_ticks(s_reg.tickField, samplePeriod, 5'h01, DEBOUNCE_MULT);
  assign sleepPer = tsm_ticks(s_reg.tickField, samplePeriod, sleepFactor, DEBOUNCE_MULT);
  assign idleTimeout = tsm_ticks(s_reg.tickField, samplePeriod, {2'h0, idleFactor}, IDLE_MULT);
  assign curPer = s_reg.sleep ? sleepPer : normalPer;
  // in duty-cycled run the interface is only awake just after a scan
  assign awake = fullRun | idleStop | (dcRun & (s_reg.awakeCnt != '0));
  assign wrData = {s_reg.shift[6:0], s_reg.sda2};

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.scan = 1'b0;
    s_next.swReset = 1'b0;
    // pin synchronisers; first stage feeds only the second
    s_next.scl1 = sclIn;
    s_next.scl2 = s_reg.scl1;
    s_next.sclPrev = s_reg.scl2;
    s_next.sda1 = sdaIn;
    s_next.sda2 = s_reg.sda1;
    s_next.sdaPrev = s_reg.sda2;
    s_next.att1 = attentionInput;
    s_next.att2 = s_reg.att1;
    s_next.attPrev = s_reg.att2;

    // millisecond prescaler and master tick
    if (s_reg.msCnt >= MS_CNT_W'(MS_CYCLES - 1))
    begin
      s_next.msCnt = '0;
      if (s_reg.tickMsCnt + 8'h01 >= tickMs)
      begin
        s_next.tickMsCnt = 8'h00;
        s_next.tick = 1'b1;
      end
      else
        s_next.tickMsCnt = s_reg.tickMsCnt + 8'h01;
    end
    else
      s_next.msCnt = s_reg.msCnt + MS_CNT_W'(1);

    // interrupt spacing in master ticks
    if (irqIssued)
      s_next.irqGap = {1'b0, s_reg.modeCfg[CFG_RATE_LSB +: 3]} + 4'h1;
    else if (s_reg.tick && s_reg.irqGap != 4'h0)
      s_next.irqGap = s_reg.irqGap - 4'h1;

    // scan scheduling; full run scans on every tick
    if (fullRun)
    begin
      s_next.scan = s_reg.tick;
      s_next.scanCnt = '0;
      s_next.idleCnt = '0;
      s_next.sleep = 1'b0;
    end
    else if (dcRun)
    begin
      if (s_reg.tick)
      begin
        if (s_reg.scanCnt + 20'h00001 >= curPer)
        begin
          s_next.scanCnt = '0;
          s_next.scan = 1'b1;
        end
        else
          s_next.scanCnt = s_reg.scanCnt + 20'h00001;
        if (s_reg.idleCnt + 20'h00001 >= idleTimeout && lpEnabled)
          s_next.sleep = 1'b1;
        else
          s_next.idleCnt = s_reg.idleCnt + 20'h00001;
      end
      if (touchDetected || !lpEnabled)
      begin
        s_next.sleep = 1'b0;
        s_next.idleCnt = '0;
      end
    end
    else
    begin
      s_next.scanCnt = '0;
      s_next.idleCnt = '0;
      s_next.sleep = 1'b0;
    end
    // wake window after each scan, one millisecond long
    if (s_reg.scan)
      s_next.awakeCnt = MS_CNT_W'(MS_CYCLES);
    else if (s_reg.awakeCnt != '0)
      s_next.awakeCnt = s_reg.awakeCnt - MS_CNT_W'(1);

    // I2C slave
    case (s_reg.st)
      ST_IDLE:
        s_next.sdaDrive = 1'b0;
      ST_ADDR, ST_REG, ST_WDATA:
      begin
        if (sclRise)
        begin
          s_next.shift = wrData;
          s_next.bitCnt = s_reg.bitCnt + 4'h1;
        end
        else if (sclFall && s_reg.bitCnt == 4'h8)
        begin
          s_next.bitCnt = 4'h0;
          s_next.sdaDrive = 1'b1;
          if (s_reg.st == ST_ADDR)
          begin
            s_next.rw = s_reg.shift[0];
            s_next.st = ST_ACKA;
            if (s_reg.shift[7:1] != SLAVE_ADDR || !awake)
            begin
              s_next.sdaDrive = 1'b0;
              s_next.st = ST_IDLE;
            end
          end
          else if (s_reg.st == ST_REG)
          begin
            s_next.ptr = s_reg.shift;
            s_next.st = ST_ACKR;
          end
          else
          begin
            s_next.st = ST_ACKW;
            s_next.ptr = s_reg.ptr + 8'h01;
            if (s_reg.ptr == ADDR_MODE_CONFIG)
            begin
              s_next.modeCfg = s_reg.shift & ~(8'h01 << CFG_RSVD_BIT);
              if (!idleStop)
              begin
                // mode bits stay put only in duty-cycled run; the pin or a soft reset leaves it
                s_next.modeCfg[CFG_RUN_BIT] = dcRun ? runBit : s_reg.shift[CFG_RUN_BIT];
                s_next.modeCfg[CFG_DUTY_N_BIT] = dcRun ? dutyN : s_reg.shift[CFG_DUTY_N_BIT];
              end
              if (!s_reg.shift[CFG_SOFTRST_N_BIT])
              begin
                s_next.swReset = 1'b1;
                s_next.modeCfg = RST_MODE_CONFIG;
                s_next.tickField = RST_MASTER_TICK;
                s_next.lowPower = RST_LOW_POWER;
              end
            end
            else if (idleStop && s_reg.ptr == ADDR_MASTER_TICK)
              s_next.tickField = (s_reg.shift > TICK_FIELD_MAX) ? TICK_FORCE_VAL : s_reg.shift;
            else if (idleStop && s_reg.ptr == ADDR_LOW_POWER)
              s_next.lowPower = s_reg.shift;
          end
        end
      end
      ST_ACKA, ST_ACKR, ST_ACKW:
        if (sclFall)
        begin
          s_next.sdaDrive = 1'b0;
          s_next.st = (s_reg.st == ST_ACKA) ? ST_REG : ST_WDATA;
          if (s_reg.st == ST_ACKA && s_reg.rw)
          begin
            s_next.shift = tsm_read(s_reg);
            s_next.sdaDrive = ~s_next.shift[7];  // msb goes out first
            s_next.bitCnt = 4'h1;
            s_next.st = ST_RDATA;
          end
        end
      ST_RDATA:
        if (sclFall)
        begin
          if (s_reg.bitCnt == 4'h8)
          begin
            s_next.sdaDrive = 1'b0;
            s_next.ptr = s_reg.ptr + 8'h01;
            s_next.st = ST_RACK;
          end
          else
          begin
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.sdaDrive = ~s_reg.shift[6];
            s_next.bitCnt = s_reg.bitCnt + 4'h1;
          end
        end
      ST_RACK:
        if (sclRise)
          s_next.rw = ~s_reg.sda2;  // keep master ack
        else if (sclFall)
        begin
          s_next.st = s_reg.rw ? ST_RDATA : ST_IDLE;
          s_next.shift = tsm_read(s_reg);
          s_next.sdaDrive = s_reg.rw & ~s_next.shift[7];
          s_next.bitCnt = 4'h1;
        end
      default:
      begin
        s_next.st = ST_IDLE;
        s_next.sdaDrive = 1'b0;
      end
    endcase
    // a start restarts framing, a stop ends it, whatever the state
    if (startCond)
    begin
      s_next.st = ST_ADDR;
      s_next.bitCnt = 4'h0;
      s_next.sdaDrive = 1'b0;
    end
    else if (stopCond)
    begin
      s_next.st = ST_IDLE;
      s_next.sdaDrive = 1'b0;
    end

    // the pin wins over a write clearing the bit in the same cycle
    if (attFall)
      s_next.modeCfg[CFG_DUTY_N_BIT] = 1'b1;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.scl1 <= 1'b1;
      s_reg.scl2 <= 1'b1;
      s_reg.sclPrev <= 1'b1;
      s_reg.sda1 <= 1'b1;
      s_reg.sda2 <= 1'b1;
      s_reg.sdaPrev <= 1'b1;
      s_reg.att1 <= 1'b1;
      s_reg.att2 <= 1'b1;
      s_reg.attPrev <= 1'b1;
      s_reg.st <= ST_IDLE;
      s_reg.tickField <= RST_MASTER_TICK;
      s_reg.lowPower <= RST_LOW_POWER;
      s_reg.modeCfg <= RST_MODE_CONFIG;
    end
    else
      s_reg <= s_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign sdaOut = 1'b0;  // open drain: only ever pulls low
  assign sdaOe = s_reg.sdaDrive;
  assign irqAllowed = s_reg.modeCfg[CFG_INTERRUPT_ENABLE_BIT_BIT] & (s_reg.irqGap == 4'h0);
  assign masterTick = s_reg.tick;
  assign scanStrobe = s_reg.scan;
  assign scanEnable = runBit;
  assign sleepScan = s_reg.sleep;
  assign sensorReset = s_reg.swReset;
  assign modeOut = {runBit, dutyN};
endmodule : tsm_mode_ctrl
`default_nettype wire

//--- verif/tsm_mode_ctrl_asserts.sv
/*
  Port checker for tsm_mode_ctrl, bound to every instance of it.
  Assumes the single core clock and the synchronous active-high rst.
*/
`timescale 1ns/100ps
`default_nettype none
module tsm_mode_ctrl_asserts
  import tsm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
)
(
  input wire logic clock,  // core clock
  input wire logic rst,  // synchronous reset
  input wire logic sdaOe,  // data pull enable
  input wire logic touchDetected,  // touch seen
  input wire logic irqIssued,  // interrupt raised
  input wire logic irqAllowed,  // interrupt permitted
  input wire logic masterTick,  // tick pulse
  input wire logic scanStrobe,  // scan start
  input wire logic scanEnable,  // run mode active
  input wire logic sleepScan,  // sleep period active
  input wire logic sensorReset,  // soft reset pulse
  input wire logic [1:0] modeOut  // {run, duty_n}
);
  // ----------------------------------------------------------------
  // helper and properties
  // ----------------------------------------------------------------
  int unsigned gapCnt_reg;
  // cycles since the last tick, so a long gap is one cheap comparison
  always_ff @(posedge clock)
  begin
    gapCnt_reg <= (rst || masterTick) ? 0 : gapCnt_reg + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // reset itself is the cause here, so this one is never disabled
  property p_reset_vals;
    disable iff (1'b0) rst |=> modeOut == 2'b01 && !sdaOe && !irqAllowed && !masterTick;
  endproperty
  property p_scan_follows;
    masterTick && modeOut == 2'b11 |=> scanStrobe;
  endproperty
  property p_stop_quiet;
    !modeOut[1] && !$past(modeOut[1]) |-> !scanStrobe && !scanEnable;
  endproperty
  property p_off_mute;
    modeOut == 2'b00 && $past(modeOut) == 2'b00 |-> !$rose(sdaOe);
  endproperty
  property p_soft_reset;
    sensorReset |=> !sensorReset && modeOut == 2'b01;
  endproperty
  property p_sleep_duty;
    sleepScan |-> modeOut == 2'b10 || $past(modeOut) == 2'b10;
  endproperty
  property p_touch_wakes;
    touchDetected |-> ##[1:2] !sleepScan;
  endproperty
  property p_irq_hold;
    irqIssued |=> !irqAllowed;
  endproperty
  property p_tick_max;
    gapCnt_reg <= 31 * MS_CYCLES;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  a_scan_follows: assert property (p_scan_follows) else $error("no scan after tick");
  a_stop_quiet: assert property (p_stop_quiet) else $error("scan in stop mode");
  a_off_mute: assert property (p_off_mute) else $error("ack while off");
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");
  a_sleep_duty: assert property (p_sleep_duty) else $error("sleep outside duty run");
  a_touch_wakes: assert property (p_touch_wakes) else $error("touch kept sleep");
  a_irq_hold: assert property (p_irq_hold) else $error("irq spacing ignored");
  a_tick_max: assert property (p_tick_max) else $error("tick gap too long");
  c_sleep: cover property ($rose(sleepScan));
  c_soft: cover property (sensorReset);
  c_off: cover property (modeOut == 2'b00);
endmodule : tsm_mode_ctrl_asserts
bind tsm_mode_ctrl tsm_mode_ctrl_asserts #(.MS_CYCLES(MS_CYCLES)) u_tsm_mode_ctrl_asserts
(
  .clock(clock),
  .rst(rst),
  .sdaOe(sdaOe),
  .touchDetected(touchDetected),
  .irqIssued(irqIssued),
  .irqAllowed(irqAllowed),
  .masterTick(masterTick),
  .scanStrobe(scanStrobe),
  .scanEnable(scanEnable),
  .sleepScan(sleepScan),
  .sensorReset(sensorReset),
  .modeOut(modeOut)
);
`default_nettype wire

//--- verif/tsm_i2c_host.sv
/*
  Host model: I2C master at a 125 ns bus clock plus the attention pin.
  Assumes the data line is resolved outside with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module tsm_i2c_host
  import tsm_pkg::*;
(
  output logic scl,  // bus clock, high between frames
  output logic sdaPull,  // high pulls data low
  output logic attention_input,  // attention pin
  input wire logic sda  // resolved data level
);
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
    attention_input = 1'b1;
  end
  // one bit: data moves only in the low phase so no false start or stop
  task automatic bitIo(input logic b, output logic s);
    sdaPull = ~b;
    #31;
    scl = 1'b1;
    #31;
    s = sda;
    #31.5;
    scl = 1'b0;
    #31.5;
  endtask : bitIo
  // start, also used as repeated start from a low clock
  task automatic start;
    sdaPull = 1'b0;
    #31;
    scl = 1'b1;
    #31;
    sdaPull = 1'b1;
    #31;
    scl = 1'b0;
    #31;
  endtask : start
  task automatic stop;
    sdaPull = 1'b1;
    #31;
    scl = 1'b1;
    #31;
    sdaPull = 1'b0;
    #62;
  endtask : stop
  // msb first; on a read d[0] is the host's ninth bit (1 = nack)
  task automatic xfer(input logic [7:0] d, input logic rd, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(rd | d[i], s);
      q[i] = s;
    end
    bitIo(rd ? d[0] : 1'b1, s);
    ack = ~s;
  endtask : xfer
  task automatic regWr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a1, a2, a3;
    start();
    xfer({DEF_SLAVE_ADDR, 1'b0}, 1'b0, q, a1);
    xfer(a, 1'b0, q, a2);
    xfer(d, 1'b0, q, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask : regWr
  task automatic regRd(input logic [7:0] a, output logic [7:0] q, output logic ok);
    logic a1, a2, a3, na;
    start();
    xfer({DEF_SLAVE_ADDR, 1'b0}, 1'b0, q, a1);
    xfer(a, 1'b0, q, a2);
    start();
    xfer({DEF_SLAVE_ADDR, 1'b1}, 1'b0, q, a3);
    xfer(8'hFF, 1'b1, q, na);
    stop();
    ok = a1 & a2 & a3;
  endtask : regRd
  // falling edge before any access while duty cycling or off
  task automatic pulseAttn;
    attention_input = 1'b0;
    #200;
    attention_input = 1'b1;
    #200;
  endtask : pulseAttn
endmodule : tsm_i2c_host
`default_nettype wire

//--- verif/test_tsm_mode_ctrl.sv
/*
  Self-checking bench: register access per mode, tick periods,
  interrupt spacing, low-power switching, attention and soft reset.
  Assumes the host model and the package constants.
*/
`timescale 1ns/100ps
`default_nettype none
module test_tsm_mode_ctrl;
  import tsm_pkg::*;
  localparam int MSC = 20;  // short millisecond keeps each tick at 100 to 160 cycles
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic touchDetected = 1'b0;
  logic irqIssued = 1'b0;
  logic [7:0] samplePeriod = 8'h01;
  logic sclIn, sdaPull, attentionInput, sdaOut, sdaOe, irqAllowed, masterTick;
  logic scanStrobe, scanEnable, sleepScan, sensorReset, ok;
  logic [1:0] modeOut;
  logic [7:0] tickModel = RST_MASTER_TICK;
  logic [7:0] lowModel = RST_LOW_POWER;
  logic [7:0] cfgModel = RST_MODE_CONFIG;
  logic [7:0] regs [4] = '{ADDR_MASTER_TICK, ADDR_LOW_POWER, ADDR_MODE_CONFIG, 8'h20};
  logic [7:0] ticks [4] = '{8'h00, 8'h1A, 8'h1B, 8'hFF};
  int failures = 0;
  int nTests = 0;
  int seed = 77;
  int n;
  wire sdaIn = ~(sdaPull | (sdaOe & ~sdaOut));  // pull-up unless someone pulls
  always #5 clock = ~clock;
  tsm_mode_ctrl #(.MS_CYCLES(MSC)) u_tsm_mode_ctrl (.clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .attentionInput(attentionInput), .samplePeriod(samplePeriod),
    .touchDetected(touchDetected), .irqIssued(irqIssued), .irqAllowed(irqAllowed), .masterTick(masterTick),
    .scanStrobe(scanStrobe), .scanEnable(scanEnable), .sleepScan(sleepScan), .sensorReset(sensorReset),
    .modeOut(modeOut));
  tsm_i2c_host u_tsm_i2c_host (.scl(sclIn), .sdaPull(sdaPull), .attention_input(attentionInput), .sda(sdaIn));
  task finalReport;
    if (failures == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finalReport
  task check(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  // write and update the model: only idle stop takes tick and low-power writes
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic idle;
    idle = !cfgModel[0] && cfgModel[2];
    u_tsm_i2c_host.regWr(a, d, ok);
    check(16'(ok), 16'h1);
    if (a == ADDR_MODE_CONFIG)
      cfgModel = d[4] ? (d & 8'hF7) : RST_MODE_CONFIG;
    if (a == ADDR_MODE_CONFIG && !d[4])
    begin
      tickModel = RST_MASTER_TICK;
      lowModel = RST_LOW_POWER;
    end
    if (idle && a == ADDR_MASTER_TICK)
      tickModel = (d > TICK_FIELD_MAX) ? TICK_FORCE_VAL : d;
    if (idle && a == ADDR_LOW_POWER)
      lowModel = d;
    cyc(1);
  endtask : wr
  task rd(input logic [7:0] a);
    logic [7:0] q;
    u_tsm_i2c_host.regRd(a, q, ok);
    check(16'(ok), 16'h1);
    check(16'(q), 16'(a == ADDR_MASTER_TICK ? tickModel : a == ADDR_LOW_POWER ? lowModel :
      a == ADDR_MODE_CONFIG ? cfgModel : RD_UNMAPPED));
    cyc(1);
  endtask : rd
  // cycles between two successive ticks, or scans when onScan is set
  task tickGap(input bit onScan);
    for (int k = 0; k < 2000 && (onScan ? scanStrobe : masterTick) !== 1'b1; k++)
      cyc(1);
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end while ((onScan ? scanStrobe : masterTick) !== 1'b1 && n < 2000);
  endtask : tickGap
  // ticks seen until a condition, bounded
  task countTicks(input bit waitSleep);
    n = 0;
    for (int k = 0; k < 5000 && (waitSleep ? sleepScan : irqAllowed) !== 1'b1; k++)
    begin
      // look before stepping so a tick right after the start is counted
      if (masterTick === 1'b1)
        n++;
      cyc(1);
    end
  endtask : countTicks
  initial
  begin
    // the full sequence needs some 30000 cycles; this leaves ample margin
    #600000;
    failures++;
    finalReport();
  end
  // main sequence
  initial
  begin
    cyc(5);
    rst = 1'b0;
    cyc(3);
    for (int i = 0; i < 4; i++)
      rd(regs[i]);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_MASTER_TICK, i < 4 ? ticks[i] : 8'($random(seed)));
      rd(ADDR_MASTER_TICK);
    end
    wr(ADDR_LOW_POWER, 8'($random(seed)));
    rd(ADDR_LOW_POWER);
    wr(ADDR_MASTER_TICK, 8'h00);
    wr(ADDR_LOW_POWER, 8'h21);
    tickGap(1'b0);
    check(16'(n), 16'(8 * MSC));
    wr(ADDR_MODE_CONFIG, 8'h1D);
    rd(ADDR_MODE_CONFIG);
    check(16'({scanEnable, modeOut}), 16'h7);
    tickGap(1'b0);
    check(16'(n), 16'(5 * MSC));
    wr(ADDR_MASTER_TICK, 8'h10);
    wr(ADDR_LOW_POWER, 8'h00);
    for (int i = 0; i < 2; i++)
      rd(regs[i]);
    for (int r = 0; r < 8; r++)
    begin
      wr(ADDR_MODE_CONFIG, 8'(r * 32 + 8'h17));
      irqIssued = 1'b1;
      cyc(1);
      irqIssued = 1'b0;
      countTicks(1'b0);
      check(16'(n), 16'(r + 1));
    end
    wr(ADDR_MODE_CONFIG, 8'h15);
    cyc(300);
    check(16'(irqAllowed), 16'h0);
    wr(ADDR_MODE_CONFIG, 8'h14);
    wr(ADDR_LOW_POWER, 8'h21);
    wr(ADDR_MODE_CONFIG, 8'h11);
    check(16'({scanEnable, modeOut}), 16'h6);
    countTicks(1'b1);
    check(16'(n >= 5 && n <= 10), 16'h1);
    tickGap(1'b0);
    check(16'(n), 16'(8 * MSC));
    touchDetected = 1'b1;
    cyc(1);
    touchDetected = 1'b0;
    cyc(2);
    check(16'(sleepScan), 16'h0);
    // two samples per scan; sleep factor 1 keeps the sleep period equal
    samplePeriod = 8'h02;
    tickGap(1'b1);
    tickGap(1'b1);
    check(16'(n), 16'(((0 + 5) / 8 + 1) * 2 * 4 * 8 * MSC));
    u_tsm_i2c_host.pulseAttn();
    cyc(10);
    cfgModel[2] = 1'b1;
    check(16'(modeOut), 16'h3);
    wr(ADDR_MODE_CONFIG, 8'h10);
    check(16'({scanEnable, modeOut}), 16'h0);
    u_tsm_i2c_host.regWr(ADDR_MODE_CONFIG, 8'h15, ok);
    check(16'(ok), 16'h0);
    u_tsm_i2c_host.pulseAttn();
    cyc(10);
    cfgModel[2] = 1'b1;
    check(16'(modeOut), 16'h1);
    rd(ADDR_MODE_CONFIG);
    wr(ADDR_MASTER_TICK, 8'h07);
    wr(ADDR_MODE_CONFIG, 8'h04);
    for (int i = 0; i < 3; i++)
      rd(regs[i]);
    finalReport();
  end
endmodule : test_tsm_mode_ctrl
`default_nettype wire
